// *** rtl/chan_mode_pkg.sv ***
// Package of register map, field positions, states and timing for channel mode control
package chan_mode_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADDR_REQUEST = 4'h0;
  localparam logic [3:0] ADDR_FUNC_REQ = 4'h1;
  localparam logic [3:0] ADDR_STOP = 4'h2;
  localparam logic [3:0] ADDR_FEEDBACK = 4'h3;
  localparam logic [3:0] ADDR_FUNC_FB = 4'h4;
  localparam logic [3:0] ADDR_CHAN_STATE = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  localparam logic [3:0] ADDR_ERROR = 4'h8;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_REQ_AUTO = 0;
  localparam int BIT_REQ_BLOCK = 1;
  localparam int BIT_REQ_MANUAL = 2;
  localparam int BIT_REQ_LOCK = 4;
  localparam int BIT_REQ_RESET = 7;
  localparam int BIT_FUNC_INSERT = 0;
  localparam int BIT_FUNC_REF = 2;
  localparam int BIT_STOP_BLOCK_END = 2;
  localparam int BIT_STOP_AXES = 3;
  localparam int BIT_STOP_AXES_SPINDLES = 4;
  localparam int BIT_FB_READY = 3;
  localparam int BIT_CH_ACTIVE = 5;
  localparam int BIT_CH_INTERRUPTED = 6;
  localparam int BIT_CH_RESET = 7;
  localparam int BIT_IRQ_REJECT = 0;
  localparam int BIT_IRQ_CHANGED = 1;
  localparam int BIT_IRQ_RESET_DONE = 2;
  localparam int BIT_ERR_REJECT = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] IRQ_NONE = 3'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int ABORT_TIME_NS = 100;
  localparam int ABORT_CYCLES_INT = (ABORT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] ABORT_CYCLES = 4'(ABORT_CYCLES_INT);
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ONE = 4'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_AUTO = 3'b001,
    MODE_BLOCK = 3'b010,
    MODE_MANUAL = 3'b100
  } mode_t;

  typedef enum logic [3:0] {
    CH_RESET = 4'b0001,
    CH_ACTIVE = 4'b0010,
    CH_INTERRUPTED = 4'b0100,
    CH_ABORT = 4'b1000
  } chan_state_t;

  typedef struct packed {
    logic block_end;
    logic axes;
    logic axes_spindles;
  } stop_req_t;

  typedef struct packed {
    logic prep_abort;
    logic halt_axes;
    logic halt_spindles;
    logic halt_at_block_end;
    logic aux_drop;
    logic block_rewind;
    logic alarm_clear;
  } channel_cmd_t;

endpackage : chan_mode_pkg

// *** rtl/channel_mode_control.sv ***
// Operating mode selection, mode change checks, stop and reset control of one channel
`timescale 1ns/10ps

// Contract
// - Priority manual, then block entry, then automatic
// - Active mode reported in separate feedback byte
// - Reference approach requested and reported in manual
// - Block insertion requested and reported in block entry
// - Three stops: axes, axes+spindles, block end
// - Reset aborts program, halts, rewinds, clears alarms
// - Channel-in-reset bit marks reset completion
// - Ready to run on feedback bit three
// - Mode change waits while channel active
// - In reset any mode change accepted
// - Interrupted allows only listed mode changes
// - After interrupted leave, only return or reset
// - Rejected change raises clearable error
// - Lock bit ignores all mode requests
// - Manual mode ignores channel controls and interlocks
module channel_mode_control (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Channel events
  input wire logic cycle_start,
  input wire logic block_end,
  input wire logic program_end,
  input wire logic drives_ready,
  input wire logic channel_interlock,
  // Channel commands
  output chan_mode_pkg::channel_cmd_t cmd,
  output logic motion_enable,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] request;
  logic [7:0] func_req;
  chan_mode_pkg::stop_req_t stop_req;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic error_reject;
  chan_mode_pkg::mode_t active_mode;
  chan_mode_pkg::mode_t prior_mode;
  chan_mode_pkg::chan_state_t chan_state;
  logic left_interrupted;
  logic [2:0] rejected_req;
  logic [3:0] abort_count;
  logic reset_cmd;
  logic abort_done;
  logic ev_reject;
  logic ev_changed;
  logic ev_reset_done;
  logic [2:0] wanted;
  logic change_pending;
  logic change_allowed;
  logic start_ok;
  logic run_ready;

  // ****************************************
  // Decoding
  // ****************************************
  // manual first; current mode passed in so no request bit leaves it unchanged
  function automatic logic [2:0] pick_mode(input logic [7:0] req, input logic [2:0] keep);
    if (req[chan_mode_pkg::BIT_REQ_MANUAL]) begin
      return chan_mode_pkg::MODE_MANUAL;
    end else if (req[chan_mode_pkg::BIT_REQ_BLOCK]) begin
      return chan_mode_pkg::MODE_BLOCK;
    end else if (req[chan_mode_pkg::BIT_REQ_AUTO]) begin
      return chan_mode_pkg::MODE_AUTO;
    end
    return keep;
  endfunction : pick_mode

  function automatic logic interrupt_ok(input logic [2:0] from, input logic [2:0] to,
                                        input logic [2:0] prior);
    logic ok;
    ok = 1'b0;
    if (from == chan_mode_pkg::MODE_AUTO && to == chan_mode_pkg::MODE_MANUAL) begin
      ok = 1'b1;
    end
    if (from == chan_mode_pkg::MODE_BLOCK && to == chan_mode_pkg::MODE_MANUAL) begin
      ok = 1'b1;
    end
    // only back to where it came from
    if (from == chan_mode_pkg::MODE_MANUAL && to == prior) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : interrupt_ok

  assign wanted = pick_mode(request, active_mode);
  assign reset_cmd = wr && addr == chan_mode_pkg::ADDR_REQUEST && wdata[chan_mode_pkg::BIT_REQ_RESET];
  assign abort_done = chan_state == chan_mode_pkg::CH_ABORT && abort_count == chan_mode_pkg::COUNT_ONE;

  assign change_pending = !request[chan_mode_pkg::BIT_REQ_LOCK] && wanted != active_mode
                          && wanted != rejected_req && chan_state != chan_mode_pkg::CH_ABORT;

  always_comb begin
    change_allowed = 1'b0;
    unique case (chan_state)
      chan_mode_pkg::CH_RESET: change_allowed = 1'b1;
      chan_mode_pkg::CH_INTERRUPTED: change_allowed = interrupt_ok(active_mode, wanted, prior_mode);
      // held while active, no verdict yet
      chan_mode_pkg::CH_ACTIVE: change_allowed = 1'b0;
      chan_mode_pkg::CH_ABORT: change_allowed = 1'b0;
    endcase
  end

  assign ev_changed = change_pending && change_allowed;
  assign ev_reject = change_pending && !change_allowed && chan_state != chan_mode_pkg::CH_ACTIVE;
  assign ev_reset_done = abort_done;

  // manual mode bypasses channel interlock and start
  assign start_ok = active_mode != chan_mode_pkg::MODE_MANUAL && cycle_start;
  assign run_ready = drives_ready && chan_state != chan_mode_pkg::CH_ABORT;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      request <= chan_mode_pkg::RESET_BYTE;
    end else if (wr && addr == chan_mode_pkg::ADDR_REQUEST) begin
      // Reset bit is a command, never stored
      request <= wdata & ~(8'h01 << chan_mode_pkg::BIT_REQ_RESET);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      func_req <= chan_mode_pkg::RESET_BYTE;
    end else if (wr && addr == chan_mode_pkg::ADDR_FUNC_REQ) begin
      func_req <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stop_req <= '0;
    end else if (wr && addr == chan_mode_pkg::ADDR_STOP) begin
      stop_req.block_end <= wdata[chan_mode_pkg::BIT_STOP_BLOCK_END];
      stop_req.axes <= wdata[chan_mode_pkg::BIT_STOP_AXES];
      stop_req.axes_spindles <= wdata[chan_mode_pkg::BIT_STOP_AXES_SPINDLES];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= chan_mode_pkg::IRQ_NONE;
    end else if (wr && addr == chan_mode_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= wdata[2:0];
    end
  end

  // ****************************************
  // Channel state
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chan_state <= chan_mode_pkg::CH_RESET;
    end else if (reset_cmd) begin
      chan_state <= chan_mode_pkg::CH_ABORT;
    end else begin
      unique case (chan_state)
        chan_mode_pkg::CH_RESET: begin
          if (start_ok && run_ready) begin
            chan_state <= chan_mode_pkg::CH_ACTIVE;
          end
        end
        chan_mode_pkg::CH_ACTIVE: begin
          if (program_end) begin
            chan_state <= chan_mode_pkg::CH_RESET;
          end else if (stop_req.axes || stop_req.axes_spindles || (stop_req.block_end && block_end)) begin
            chan_state <= chan_mode_pkg::CH_INTERRUPTED;
          end
        end
        chan_mode_pkg::CH_INTERRUPTED: begin
          if (start_ok && run_ready && !stop_req.axes && !stop_req.axes_spindles && !stop_req.block_end) begin
            chan_state <= chan_mode_pkg::CH_ACTIVE;
          end
        end
        chan_mode_pkg::CH_ABORT: begin
          // reset status only once abort finished
          if (abort_done) begin
            chan_state <= chan_mode_pkg::CH_RESET;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      abort_count <= chan_mode_pkg::COUNT_ZERO;
    end else if (reset_cmd) begin
      abort_count <= chan_mode_pkg::ABORT_CYCLES;
    end else if (abort_count != chan_mode_pkg::COUNT_ZERO) begin
      abort_count <= abort_count - chan_mode_pkg::COUNT_ONE;
    end
  end

  // ****************************************
  // Mode change
  // ****************************************
  // feedback follows the applied mode only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_mode <= chan_mode_pkg::MODE_MANUAL;
    end else if (ev_changed) begin
      active_mode <= chan_mode_pkg::mode_t'(wanted);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prior_mode <= chan_mode_pkg::MODE_MANUAL;
    end else if (ev_changed) begin
      prior_mode <= active_mode;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left_interrupted <= 1'b0;
    end else if (chan_state == chan_mode_pkg::CH_RESET) begin
      left_interrupted <= 1'b0;
    end else if (ev_changed && chan_state == chan_mode_pkg::CH_INTERRUPTED) begin
      left_interrupted <= 1'b1;
    end
  end

  // One verdict per request, avoids repeated errors
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rejected_req <= 3'h0;
    end else if (ev_reject) begin
      rejected_req <= wanted;
    end else if (wanted != rejected_req) begin
      rejected_req <= 3'h0;
    end
  end

  // error stays until cleared, set wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      error_reject <= 1'b0;
    end else if (ev_reject) begin
      error_reject <= 1'b1;
    end else if (wr && addr == chan_mode_pkg::ADDR_ERROR && wdata[chan_mode_pkg::BIT_ERR_REJECT]) begin
      error_reject <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= chan_mode_pkg::IRQ_NONE;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (rd && addr == chan_mode_pkg::ADDR_IRQ_STATUS) begin
          irq_status[i] <= 1'b0;
        end
      end
      // Set wins over read clear
      if (ev_reject) begin
        irq_status[chan_mode_pkg::BIT_IRQ_REJECT] <= 1'b1;
      end
      if (ev_changed) begin
        irq_status[chan_mode_pkg::BIT_IRQ_CHANGED] <= 1'b1;
      end
      if (ev_reset_done) begin
        irq_status[chan_mode_pkg::BIT_IRQ_RESET_DONE] <= 1'b1;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // Channel commands
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else begin
      cmd.prep_abort <= reset_cmd;
      cmd.aux_drop <= reset_cmd;
      cmd.block_rewind <= reset_cmd;
      cmd.alarm_clear <= reset_cmd;
      cmd.halt_axes <= stop_req.axes || stop_req.axes_spindles || reset_cmd
                       || chan_state == chan_mode_pkg::CH_ABORT;
      cmd.halt_spindles <= stop_req.axes_spindles || reset_cmd || chan_state == chan_mode_pkg::CH_ABORT;
      cmd.halt_at_block_end <= stop_req.block_end;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      motion_enable <= 1'b0;
    end else begin
      motion_enable <= run_ready && !stop_req.axes && !stop_req.axes_spindles
                       && (active_mode == chan_mode_pkg::MODE_MANUAL || !channel_interlock);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= chan_mode_pkg::RESET_BYTE;
    end else if (rd) begin
      rdata <= chan_mode_pkg::RESET_BYTE;
      unique case (addr)
        chan_mode_pkg::ADDR_REQUEST: rdata <= request;
        chan_mode_pkg::ADDR_FUNC_REQ: rdata <= func_req;
        chan_mode_pkg::ADDR_STOP: begin
          rdata[chan_mode_pkg::BIT_STOP_BLOCK_END] <= stop_req.block_end;
          rdata[chan_mode_pkg::BIT_STOP_AXES] <= stop_req.axes;
          rdata[chan_mode_pkg::BIT_STOP_AXES_SPINDLES] <= stop_req.axes_spindles;
        end
        chan_mode_pkg::ADDR_FEEDBACK: begin
          rdata[2:0] <= active_mode;
          rdata[chan_mode_pkg::BIT_FB_READY] <= run_ready;
        end
        chan_mode_pkg::ADDR_FUNC_FB: begin
          rdata[chan_mode_pkg::BIT_FUNC_REF] <= active_mode == chan_mode_pkg::MODE_MANUAL
                                                && func_req[chan_mode_pkg::BIT_FUNC_REF];
          rdata[chan_mode_pkg::BIT_FUNC_INSERT] <= active_mode == chan_mode_pkg::MODE_BLOCK
                                                   && func_req[chan_mode_pkg::BIT_FUNC_INSERT];
        end
        chan_mode_pkg::ADDR_CHAN_STATE: begin
          rdata[chan_mode_pkg::BIT_CH_ACTIVE] <= chan_state == chan_mode_pkg::CH_ACTIVE;
          rdata[chan_mode_pkg::BIT_CH_INTERRUPTED] <= chan_state == chan_mode_pkg::CH_INTERRUPTED;
          rdata[chan_mode_pkg::BIT_CH_RESET] <= chan_state == chan_mode_pkg::CH_RESET;
          rdata[0] <= left_interrupted;
        end
        chan_mode_pkg::ADDR_IRQ_STATUS: rdata[2:0] <= irq_status;
        chan_mode_pkg::ADDR_IRQ_MASK: rdata[2:0] <= irq_mask;
        chan_mode_pkg::ADDR_ERROR: rdata[chan_mode_pkg::BIT_ERR_REJECT] <= error_reject;
        default: rdata <= chan_mode_pkg::RESET_BYTE;
      endcase
    end
  end

endmodule : channel_mode_control

// *** tb/channel_mode_props.sv ***
// Port-level concurrent checks for the channel mode control block
`timescale 1ns/10ps
module channel_mode_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Commands and interrupt
  input wire chan_mode_pkg::channel_cmd_t cmd,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_unmapped_reads_zero: assert property (rd && addr > 4'h8 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  a_feedback_one_mode: assert property (rd && addr == chan_mode_pkg::ADDR_FEEDBACK
    |=> $onehot(rdata[2:0]) && rdata[7:4] == 4'h0) else $error("feedback mode not one-hot");
  a_func_fb_exclusive: assert property (rd && addr == chan_mode_pkg::ADDR_FUNC_FB
    |=> rdata[7:3] == 5'h00 && !rdata[1] && !(rdata[0] && rdata[2])) else $error("bad function feedback");
  a_state_exclusive: assert property (rd && addr == chan_mode_pkg::ADDR_CHAN_STATE
    |=> $onehot0(rdata[7:5])) else $error("several channel states at once");
  // All four cleanup pulses rise a cycle after reset; only block rewind is checked to drop the cycle after
  a_reset_pulses: assert property (wr && addr == chan_mode_pkg::ADDR_REQUEST && wdata[7]
    |=> cmd.prep_abort && cmd.aux_drop && cmd.block_rewind && cmd.alarm_clear ##1 !cmd.block_rewind)
    else $error("reset cleanup pulses wrong");
  a_reset_halts: assert property (wr && addr == chan_mode_pkg::ADDR_REQUEST && wdata[7]
    |-> ##[1:2] cmd.halt_axes && cmd.halt_spindles) else $error("reset did not halt");
  a_stop_axes: assert property (wr && addr == chan_mode_pkg::ADDR_STOP && wdata[3]
    |-> ##[1:2] cmd.halt_axes) else $error("axis stop not applied");
  a_stop_spindles: assert property (wr && addr == chan_mode_pkg::ADDR_STOP && wdata[4]
    |-> ##[1:2] cmd.halt_axes && cmd.halt_spindles) else $error("axis and spindle stop not applied");
  a_stop_block_end: assert property (wr && addr == chan_mode_pkg::ADDR_STOP && wdata[2]
    |-> ##[1:2] cmd.halt_at_block_end) else $error("block end stop not applied");
  a_masked_irq_low: assert property (wr && addr == chan_mode_pkg::ADDR_IRQ_MASK && wdata[2:0] == 3'h0
    |=> !irq) else $error("interrupt high with all masked");
endmodule : channel_mode_props

// *** tb/machine_model.sv ***
// Machine side model: drive readiness, block end and program end events
`timescale 1ns/10ps
module machine_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bench control
  input wire logic drives_ok,
  input wire logic finish,
  // Channel side
  input wire logic motion_enable,
  output logic drives_ready,
  output logic block_end,
  output logic program_end
);
  logic [2:0] block_count;
  logic finish_seen;

  // Drives report ready a cycle after the bench allows it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drives_ready <= 1'b0;
    end else begin
      drives_ready <= drives_ok;
    end
  end

  // Blocks only finish while axes may move
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      block_count <= 3'h0;
      block_end <= 1'b0;
    end else begin
      block_count <= motion_enable ? block_count + 3'h1 : 3'h0;
      block_end <= motion_enable && block_count == 3'h7;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      finish_seen <= 1'b0;
      program_end <= 1'b0;
    end else begin
      finish_seen <= finish;
      program_end <= finish && !finish_seen;
    end
  end
endmodule : machine_model

// *** tb/tb_channel_mode_control.sv ***
// Self-checking testbench for channel mode control
`timescale 1ns/10ps
module tb_channel_mode_control;
  logic clock;
  logic rst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic cycle_start;
  logic block_end;
  logic program_end;
  logic drives_ready;
  logic channel_interlock;
  chan_mode_pkg::channel_cmd_t cmd;
  logic motion_enable;
  logic irq;
  logic drives_ok;
  logic finish;
  logic [7:0] got;
  int errors;
  int cmp_count;
  logic [7:0] req_tab [6] = '{8'h03, 8'h01, 8'h05, 8'h02, 8'h06, 8'h01};
  logic [7:0] mode_tab [6] = '{8'h02, 8'h01, 8'h04, 8'h02, 8'h04, 8'h01};

  channel_mode_control u_channel_mode_control (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cycle_start(cycle_start), .block_end(block_end),
    .program_end(program_end), .drives_ready(drives_ready), .channel_interlock(channel_interlock),
    .cmd(cmd), .motion_enable(motion_enable), .irq(irq));
  machine_model u_machine_model (.clock(clock), .rst_n(rst_n), .drives_ok(drives_ok), .finish(finish),
    .motion_enable(motion_enable), .drives_ready(drives_ready), .block_end(block_end),
    .program_end(program_end));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ********
  // Bus tasks
  // ********
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] msk, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    cmp_count++;
    if ((d & msk) !== exp) begin
      errors++;
      $display("BAD %0t: reg %0h read %0h want %0h", $time, a, d, exp);
    end
  endtask : rd_chk

  task automatic chk_bit(input logic g, input logic exp);
    cmp_count++;
    if (g !== exp) begin
      errors++;
      $display("BAD %0t: flag %0b want %0b", $time, g, exp);
    end
  endtask : chk_bit

  task automatic start_pulse;
    @(posedge clock);
    cycle_start <= 1'b1;
    @(posedge clock);
    cycle_start <= 1'b0;
  endtask : start_pulse

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Whole run is under two hundred cycles, so this leaves ample margin
  initial begin
    #200000;
    errors++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cycle_start = 1'b0;
    channel_interlock = 1'b0;
    drives_ok = 1'b1;
    finish = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd_chk(chan_mode_pkg::ADDR_FEEDBACK, 8'hFF, 8'h0C);
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h80);
    rd_chk(chan_mode_pkg::ADDR_ERROR, 8'hFF, 8'h00);
    rd_chk(4'hC, 8'hFF, 8'h00);
    @(posedge clock);
    drives_ok <= 1'b0;
    repeat (3) @(posedge clock);
    rd_chk(chan_mode_pkg::ADDR_FEEDBACK, 8'h08, 8'h00);
    drives_ok <= 1'b1;
    repeat (3) @(posedge clock);
    $display("test reset_values done");
    wr_reg(chan_mode_pkg::ADDR_IRQ_MASK, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr_reg(chan_mode_pkg::ADDR_REQUEST, req_tab[i]);
      rd_chk(chan_mode_pkg::ADDR_FEEDBACK, 8'h07, mode_tab[i]);
    end
    chk_bit(irq, 1'b0);
    wr_reg(chan_mode_pkg::ADDR_IRQ_MASK, 8'h07);
    #1;
    chk_bit(irq, 1'b1);
    rd_chk(chan_mode_pkg::ADDR_IRQ_STATUS, 8'h02, 8'h02);
    chk_bit(irq, 1'b0);
    $display("test priority done");
    wr_reg(chan_mode_pkg::ADDR_REQUEST, 8'h14);
    rd_chk(chan_mode_pkg::ADDR_FEEDBACK, 8'h07, 8'h01);
    rd_chk(chan_mode_pkg::ADDR_ERROR, 8'hFF, 8'h00);
    wr_reg(chan_mode_pkg::ADDR_REQUEST, 8'h04);
    wr_reg(chan_mode_pkg::ADDR_FUNC_REQ, 8'h05);
    rd_chk(chan_mode_pkg::ADDR_FUNC_FB, 8'hFF, 8'h04);
    @(posedge clock);
    channel_interlock <= 1'b1;
    start_pulse();
    repeat (2) @(posedge clock);
    chk_bit(motion_enable, 1'b1);
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h80);
    wr_reg(chan_mode_pkg::ADDR_REQUEST, 8'h02);
    rd_chk(chan_mode_pkg::ADDR_FUNC_FB, 8'hFF, 8'h01);
    chk_bit(motion_enable, 1'b0);
    @(posedge clock);
    channel_interlock <= 1'b0;
    wr_reg(chan_mode_pkg::ADDR_FUNC_REQ, 8'h00);
    rd_reg(chan_mode_pkg::ADDR_IRQ_STATUS, got);
    $display("test functions done");
    wr_reg(chan_mode_pkg::ADDR_REQUEST, 8'h82);
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h00);
    // Bench treats the reset as finished only on the in-reset flag
    got = 8'h00;
    for (int n = 0; n < 20 && got[7] !== 1'b1; n++) begin
      rd_reg(chan_mode_pkg::ADDR_CHAN_STATE, got);
    end
    chk_bit(got[7], 1'b1);
    rd_chk(chan_mode_pkg::ADDR_IRQ_STATUS, 8'h04, 8'h04);
    $display("test reset done");
    wr_reg(chan_mode_pkg::ADDR_REQUEST, 8'h01);
    start_pulse();
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h20);
    wr_reg(chan_mode_pkg::ADDR_REQUEST, 8'h04);
    rd_chk(chan_mode_pkg::ADDR_FEEDBACK, 8'h07, 8'h01);
    wr_reg(chan_mode_pkg::ADDR_STOP, 8'h1C);
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h40);
    rd_chk(chan_mode_pkg::ADDR_FEEDBACK, 8'h07, 8'h04);
    rd_reg(chan_mode_pkg::ADDR_IRQ_STATUS, got);
    wr_reg(chan_mode_pkg::ADDR_REQUEST, 8'h02);
    rd_chk(chan_mode_pkg::ADDR_FEEDBACK, 8'h07, 8'h04);
    rd_chk(chan_mode_pkg::ADDR_ERROR, 8'h01, 8'h01);
    rd_chk(chan_mode_pkg::ADDR_IRQ_STATUS, 8'h01, 8'h01);
    wr_reg(chan_mode_pkg::ADDR_ERROR, 8'h01);
    rd_chk(chan_mode_pkg::ADDR_ERROR, 8'h01, 8'h00);
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h40);
    wr_reg(chan_mode_pkg::ADDR_REQUEST, 8'h01);
    rd_chk(chan_mode_pkg::ADDR_FEEDBACK, 8'h07, 8'h01);
    wr_reg(chan_mode_pkg::ADDR_STOP, 8'h00);
    start_pulse();
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h20);
    // Block end stop waits for the model's next block end
    wr_reg(chan_mode_pkg::ADDR_STOP, 8'h04);
    repeat (12) @(posedge clock);
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h40);
    wr_reg(chan_mode_pkg::ADDR_STOP, 8'h00);
    start_pulse();
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h20);
    @(posedge clock);
    finish <= 1'b1;
    @(posedge clock);
    finish <= 1'b0;
    repeat (3) @(posedge clock);
    rd_chk(chan_mode_pkg::ADDR_CHAN_STATE, 8'hE0, 8'h80);
    $display("test interrupted done");
    end_sim();
  end
endmodule : tb_channel_mode_control

bind channel_mode_control channel_mode_props u_channel_mode_props (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmd(cmd), .irq(irq));
